//--- serial0_pkg.sv
// Shared constants and types for the serial channel zero pin control.
// What this block does
// - Both serial channels may run together
// - Two-line uses SDA/SCL; three-line uses own pins
// - Two-line offers bus protocol or plain serial
// - Mode field bits 3:2 decode four modes
// - Bit 1: slave external clock, master internal
// - Bit 0: two-line SDA input hi-Z or output
// - Three-line receive returns serial-out pin to port
// - Mode register: 4-bit read/write at 0FH
// - Every reset kind clears the mode register
// - Clock select bits pick master shift rate
// - Wait condition bits pause communication
// - Writing the go bit starts or releases
// - Acknowledge bit: read received, set sent level
// - Status bits flag counts of 8 and 9
// - Status bits show start and bus busy
// - Interrupt mode bits choose interrupt point
// - Wait status bit shows wait state
package serial0_pkg;

////////////////////////////////////////////////////////////////////////////
// Register indices; byte address is four times the index
localparam logic [5:0] IDX_MODE = 6'h0F;
localparam logic [5:0] IDX_CLK_SEL = 6'h10;
localparam logic [5:0] IDX_WAIT_CTRL = 6'h11;
localparam logic [5:0] IDX_STATUS = 6'h12;
localparam logic [5:0] IDX_IRQ_MODE = 6'h13;
localparam logic [5:0] IDX_WAIT_STAT = 6'h14;
localparam logic [5:0] IDX_IRQ_STATUS = 6'h15;
localparam logic [5:0] IDX_IRQ_CLEAR = 6'h16;
localparam logic [5:0] IDX_IRQ_ENABLE = 6'h17;

////////////////////////////////////////////////////////////////////////////
// Field positions
localparam int WC_GO_BIT = 2;
localparam int WC_ACK_BIT = 3;
localparam int IRQ_POINT = 0;
localparam int IRQ_WAIT = 1;
localparam int IRQ_STOP = 2;

// Reset values
localparam logic [3:0] MODE_RESET = 4'h0;
localparam logic [1:0] FIELD2_RESET = 2'h0;
localparam logic [2:0] IRQ_RESET = 3'h0;

// Timing counts: bit counts and master half period base in MCLK cycles
localparam logic [3:0] COUNT_EIGHT = 4'h8;
localparam logic [3:0] COUNT_NINE = 4'h9;
localparam int HALF_DIV_BASE = 11;

////////////////////////////////////////////////////////////////////////////
// Channel mode, in field order 00, 01, 10, 11
typedef enum logic [1:0] {M_UNUSED, M_BUS, M_TWO_SIO, M_THREE_SIO} mode_e;

// Mode register layout
typedef struct packed {
	mode_e mode;
	logic master;
	logic tx;
} mode_reg_s;

// Pin drive bundle
typedef struct packed {
	logic sda_o;
	logic sda_oe;
	logic scl_o;
	logic scl_oe;
	logic sck_o;
	logic sck_oe;
	logic so_o;
	logic so_oe;
} pin_out_s;

endpackage : serial0_pkg

//--- serial0_pin_sync.sv
// Two-stage pin synchroniser with edge detect per bit.
`timescale 1ns/1ps
module serial0_pin_sync #(
	parameter int WIDTH = 4
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);

	////////////////////////////////////////////////////////////////////////
	// One synchroniser per pin; the first flop feeds only the second
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_pin
			logic meta; // First stage, read by second only
			logic prev; // Previous synced level for edges
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					meta <= 1'b1;
					level[g] <= 1'b1;
					prev <= 1'b1;
				end else begin
					meta <= pin_in[g];
					level[g] <= meta;
					prev <= level[g];
				end
			end
			// Edges seen on the synchronised level only
			assign rise[g] = level[g] & ~prev;
			assign fall[g] = ~level[g] & prev;
		end
	endgenerate

endmodule : serial0_pin_sync

//--- serial0_mode_pin_control.sv
// Mode, clock and pin routing control of serial channel zero.
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module serial0_mode_pin_control #(
	parameter int HALF_DIV = serial0_pkg::HALF_DIV_BASE
) (
	input wire logic MCLK,
	input wire logic RESET,
	input wire logic WATCHDOG_STACK_RESET,
	input wire logic CE_RESET,
	input wire logic CLOCK_STOP,
	input wire logic [7:0] ADDRESS,
	input wire logic READ,
	input wire logic WRITE,
	input wire logic [31:0] WRITEDATA,
	input wire logic [3:0] BYTEENABLE,
	output logic [31:0] READDATA,
	output logic WAITREQUEST,
	input wire logic SDA_IN,
	input wire logic SCL_IN,
	input wire logic CH0_THREE_LINE_CLOCK_PIN_IN,
	input wire logic SI0_IN,
	output serial0_pkg::pin_out_s PIN_OUT,
	output logic [4:0] PIN_SERIAL,
	input wire logic SHIFT_OUT,
	output logic SHIFT_IN,
	output logic SHIFT_SAMPLE,
	output logic SHIFT_ADVANCE,
	output logic IRQ
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	serial0_pkg::mode_reg_s mode_q; // Mode register
	logic [1:0] rate; // Master shift clock rate
	logic [1:0] wait_cond; // Wait after count 8 (bit 0), 9 (bit 1)
	logic ack_send; // Level sent as acknowledge
	logic ack_recv; // Acknowledge seen at the ninth clock
	logic [1:0] irq_mode; // Interrupt point select
	logic [2:0] irq_stat; // Sticky events
	logic [2:0] irq_en; // Event enables
	logic active; // Communication started
	logic waiting; // Paused by a wait condition
	logic [3:0] bit_cnt; // Shift clock counter
	logic [3:0] next_cnt; // Count after the next rising edge
	logic busy; // Bus busy, start to stop
	logic start_flag; // Start seen, no clock since
	logic waitreq; // Bus handshake state
	logic [7:0] div_cnt; // Master clock divider
	logic clk_int; // Internal shift clock, idles high
	logic [3:0] lvl, rise, fall; // Synced SDA, SCL, CH0_THREE_LINE_CLOCK_PIN, SI0
	logic req, wr_ok, go_wr, soft_rst, used, two_line, bus_mode;
	logic run_int, tick, sh_rise, sh_fall, start_c, stop_c;
	logic wait_hit, irq_point;
	logic [7:0] half_m1;
	serial0_pkg::pin_out_s next_pin;
	logic [4:0] next_serial;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	serial0_pin_sync #(.WIDTH(4)) u_sync (
		.clk(MCLK),
		.reset(RESET),
		.pin_in({SI0_IN, CH0_THREE_LINE_CLOCK_PIN_IN, SCL_IN, SDA_IN}),
		.level(lvl),
		.rise(rise),
		.fall(fall)
	);

	////////////////////////////////////////////////////////////////////////
	// Decode; nothing here looks at channel one, so both run freely
	assign used = mode_q.mode != serial0_pkg::M_UNUSED;
	assign bus_mode = mode_q.mode == serial0_pkg::M_BUS;
	assign two_line = bus_mode || mode_q.mode == serial0_pkg::M_TWO_SIO;
	assign soft_rst = WATCHDOG_STACK_RESET | CE_RESET | CLOCK_STOP;
	assign req = READ | WRITE;
	// A write takes effect only at the edge where waitrequest is low
	assign wr_ok = WRITE && !waitreq && BYTEENABLE[0];
	assign go_wr = wr_ok && ADDRESS[7:2] == serial0_pkg::IDX_WAIT_CTRL
		&& WRITEDATA[serial0_pkg::WC_GO_BIT];

	////////////////////////////////////////////////////////////////////////
	// Bus handshake: one wait cycle, then one cycle with waitrequest low
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			waitreq <= 1'b1;
		end else if (req && waitreq) begin
			waitreq <= 1'b0;
		end else begin
			waitreq <= 1'b1;
		end
	end
	assign WAITREQUEST = waitreq;

	// Read data is caught one edge early so it stands while waitreq is low
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			READDATA <= 32'h0;
		end else if (READ && waitreq) begin
			unique case (ADDRESS[7:2])
				serial0_pkg::IDX_MODE: READDATA <= {28'h0, mode_q};
				serial0_pkg::IDX_CLK_SEL: READDATA <= {30'h0, rate};
				// Reads see the received acknowledge
				serial0_pkg::IDX_WAIT_CTRL:
					READDATA <= {28'h0, ack_recv, active, wait_cond};
				// Count flags bit 3 = 8, bit 2 = 9; start and busy
				serial0_pkg::IDX_STATUS: READDATA <= {28'h0,
					bit_cnt == serial0_pkg::COUNT_EIGHT,
					bit_cnt == serial0_pkg::COUNT_NINE, start_flag, busy};
				serial0_pkg::IDX_IRQ_MODE: READDATA <= {30'h0, irq_mode};
				serial0_pkg::IDX_WAIT_STAT: READDATA <= {31'h0, waiting};
				serial0_pkg::IDX_IRQ_STATUS: READDATA <= {29'h0, irq_stat};
				serial0_pkg::IDX_IRQ_ENABLE: READDATA <= {29'h0, irq_en};
				// Clear register and unmapped words read zero
				default: READDATA <= 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode register; every reset kind clears it and wins over a write
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			mode_q <= serial0_pkg::MODE_RESET;
		end else if (soft_rst) begin
			mode_q <= serial0_pkg::MODE_RESET;
		end else if (wr_ok && ADDRESS[7:2] == serial0_pkg::IDX_MODE) begin
			mode_q <= WRITEDATA[3:0];
		end
	end

	// Plain configuration fields
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			rate <= serial0_pkg::FIELD2_RESET;
			wait_cond <= serial0_pkg::FIELD2_RESET;
			irq_mode <= serial0_pkg::FIELD2_RESET;
			irq_en <= serial0_pkg::IRQ_RESET;
			ack_send <= 1'b0;
		end else if (wr_ok) begin
			unique case (ADDRESS[7:2])
				serial0_pkg::IDX_CLK_SEL: rate <= WRITEDATA[1:0];
				serial0_pkg::IDX_WAIT_CTRL: begin
					wait_cond <= WRITEDATA[1:0];
					ack_send <= WRITEDATA[serial0_pkg::WC_ACK_BIT];
				end
				serial0_pkg::IDX_IRQ_MODE: irq_mode <= WRITEDATA[1:0];
				serial0_pkg::IDX_IRQ_ENABLE: irq_en <= WRITEDATA[2:0];
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Start and release; a wait hit in the same cycle as go still waits
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			active <= 1'b0;
		end else if (soft_rst || !used) begin
			active <= 1'b0;
		end else if (go_wr) begin
			active <= 1'b1;
		end
	end

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			waiting <= 1'b0;
		end else if (wait_hit) begin
			waiting <= 1'b1;
		end else if (go_wr || !active) begin
			waiting <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Master shift clock; rate doubles the half period per step
	assign half_m1 = 8'((HALF_DIV << rate) - 1);
	assign run_int = used && mode_q.master && active && !waiting;
	assign tick = run_int && div_cnt == half_m1;

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			div_cnt <= 8'h0;
			clk_int <= 1'b1;
		end else if (!run_int) begin
			// Stopped clock rests high, so a wait never cuts a pulse short
			div_cnt <= 8'h0;
			clk_int <= 1'b1;
		end else if (tick) begin
			div_cnt <= 8'h0;
			clk_int <= ~clk_int;
		end else begin
			div_cnt <= div_cnt + 8'h1;
		end
	end

	// Shift clock edges: own clock as master, pin edges as slave
	always_comb begin
		sh_rise = 1'b0;
		sh_fall = 1'b0;
		if (mode_q.master) begin
			sh_rise = tick && !clk_int;
			sh_fall = tick && clk_int;
		end else if (used && active && !waiting) begin
			sh_rise = two_line ? rise[1] : rise[2];
			sh_fall = two_line ? fall[1] : fall[2];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bit counter: nine clocks per byte on the bus, eight otherwise
	always_comb begin
		next_cnt = bit_cnt + 4'h1;
		if (bit_cnt >= (bus_mode ? serial0_pkg::COUNT_NINE
			: serial0_pkg::COUNT_EIGHT)) begin
			next_cnt = 4'h1;
		end
	end

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			bit_cnt <= 4'h0;
		end else if (!used || start_c) begin
			bit_cnt <= 4'h0;
		end else if (sh_rise) begin
			bit_cnt <= next_cnt;
		end
	end

	// Wait conditions trip on the rising edge that reaches 8 or 9
	assign wait_hit = sh_rise && ((wait_cond[0]
		&& next_cnt == serial0_pkg::COUNT_EIGHT) || (wait_cond[1]
		&& next_cnt == serial0_pkg::COUNT_NINE));

	// Acknowledge level is caught on the ninth rising edge
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			ack_recv <= 1'b0;
		end else if (sh_rise && next_cnt == serial0_pkg::COUNT_NINE) begin
			ack_recv <= lvl[0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Start and stop conditions, bus protocol mode only
	assign start_c = bus_mode && fall[0] && lvl[1];
	assign stop_c = bus_mode && rise[0] && lvl[1];

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			busy <= 1'b0;
			start_flag <= 1'b0;
		end else if (!bus_mode) begin
			busy <= 1'b0;
			start_flag <= 1'b0;
		end else if (start_c) begin
			busy <= 1'b1;
			start_flag <= 1'b1;
		end else if (stop_c) begin
			busy <= 1'b0;
			start_flag <= 1'b0;
		end else if (sh_rise) begin
			start_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt point: 00 count 8, 01 count 9, 10 start, 11 stop
	always_comb begin
		unique case (irq_mode)
			2'h0: irq_point = sh_rise && next_cnt == serial0_pkg::COUNT_EIGHT;
			2'h1: irq_point = sh_rise && next_cnt == serial0_pkg::COUNT_NINE;
			2'h2: irq_point = start_c;
			2'h3: irq_point = stop_c;
		endcase
	end

	// Sticky events; a new event beats a clear in the same cycle
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			irq_stat <= serial0_pkg::IRQ_RESET;
		end else begin
			irq_stat <= (irq_stat & ~((wr_ok && ADDRESS[7:2]
				== serial0_pkg::IDX_IRQ_CLEAR) ? WRITEDATA[2:0] : 3'h0))
				| {stop_c, wait_hit, irq_point};
		end
	end

	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(irq_stat & irq_en);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin routing; ownership bits {SI0, SO0, CH0_THREE_LINE_CLOCK_PIN, SCL, SDA}
	always_comb begin
		next_pin = '0;
		next_serial = 5'h0;
		unique case (mode_q.mode)
			serial0_pkg::M_BUS: begin
				next_serial = 5'h03;
				// Open drain; ninth bit turns the line round for the ack
				if (bit_cnt == serial0_pkg::COUNT_EIGHT) begin
					next_pin.sda_oe = !mode_q.tx && !ack_send;
				end else begin
					next_pin.sda_oe = mode_q.tx && !SHIFT_OUT;
				end
				next_pin.scl_oe = mode_q.master && !clk_int;
			end
			serial0_pkg::M_TWO_SIO: begin
				next_serial = 5'h03;
				next_pin.sda_o = SHIFT_OUT;
				next_pin.sda_oe = mode_q.tx;
				next_pin.scl_o = clk_int;
				next_pin.scl_oe = mode_q.master;
			end
			serial0_pkg::M_THREE_SIO: begin
				// Serial-out pin goes back to the port when receiving
				next_serial = {1'b1, mode_q.tx, 3'h4};
				next_pin.so_o = SHIFT_OUT;
				next_pin.so_oe = mode_q.tx;
				next_pin.sck_o = clk_int;
				next_pin.sck_oe = mode_q.master;
			end
			// Port keeps every pin; direction and data bits ignored
			serial0_pkg::M_UNUSED: begin
			end
		endcase
	end

	// Port direction flags stay with software and the port block
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			PIN_OUT <= '0;
			PIN_SERIAL <= 5'h0;
		end else begin
			PIN_OUT <= next_pin;
			PIN_SERIAL <= next_serial;
		end
	end

	// Data handed to and from the shift register
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			SHIFT_IN <= 1'b0;
			SHIFT_SAMPLE <= 1'b0;
			SHIFT_ADVANCE <= 1'b0;
		end else begin
			SHIFT_SAMPLE <= sh_rise;
			SHIFT_ADVANCE <= sh_fall;
			if (sh_rise) begin
				SHIFT_IN <= two_line ? lvl[0] : lvl[3];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RESET);

	chk_unused_pins: assert property (!used |=> PIN_SERIAL == 5'h0
		&& !PIN_OUT.sda_oe && !PIN_OUT.so_oe) else $error("unused mode drives");
	chk_two_line_pins: assert property (two_line |=> PIN_SERIAL == 5'h03
		&& !PIN_OUT.sck_oe) else $error("two-line pin set wrong");
	chk_rx_sda_hiz: assert property (
		mode_q.mode == serial0_pkg::M_TWO_SIO && !mode_q.tx
		|=> !PIN_OUT.sda_oe) else $error("receive drives SDA");
	chk_so_to_port: assert property (
		mode_q.mode == serial0_pkg::M_THREE_SIO && !mode_q.tx
		|=> !PIN_SERIAL[3] && !PIN_OUT.so_oe) else $error("SO0 kept");
	chk_slave_clock: assert property (used && !mode_q.master
		|=> !PIN_OUT.scl_oe && !PIN_OUT.sck_oe) else $error("slave drives");
	chk_mode_write: assert property (wr_ok && !soft_rst
		&& ADDRESS[7:2] == serial0_pkg::IDX_MODE
		|=> mode_q == $past(WRITEDATA[3:0])) else $error("mode not stored");
	chk_soft_clear: assert property (soft_rst |=> mode_q == 4'h0)
		else $error("mode not cleared");
	chk_wait_hold: assert property (waiting && !go_wr && active
		|=> waiting && $stable(bit_cnt)) else $error("wait lost");
	chk_go_release: assert property (go_wr && used && !wait_hit
		&& !soft_rst |=> active && !waiting) else $error("go ignored");
	chk_bus_answer: assert property (req && waitreq
		|=> !WAITREQUEST ##1 WAITREQUEST) else $error("bad handshake");

	cov_bus_start: cover property (start_c ##[1:200] sh_rise);
	cov_wait_nine: cover property (wait_hit && bit_cnt == 4'h8);
	cov_three_tx: cover property (PIN_OUT.so_oe && PIN_OUT.sck_oe);

endmodule : serial0_mode_pin_control

//--- serial0_far_end.sv
// Far-end serial peripheral model on the channel zero pins.
`timescale 1ns/1ps
module serial0_far_end (
	input wire serial0_pkg::pin_out_s pin_out,
	input wire logic go,
	input wire logic sda_pull,
	input wire logic [7:0] tx_byte,
	output logic busy,
	output logic sda,
	output logic scl,
	output logic ch0_three_line_clock_pin,
	output logic si0
);
////////////////////////////////////////////////////////////////////////////
logic clk_far; // Far clock, stands high between frames
logic dat; // Far serial data bit

initial begin
	clk_far = 1'h1;
	dat = 1'h0;
	busy = 1'h0;
end

// One frame of eight bits at an 80 ns period, data moves on the fall
always @(posedge go) begin
	busy = 1'h1;
	for (int i = 7; i >= 0; i--) begin
		clk_far = 1'h0;
		dat = tx_byte[i];
		#40;
		clk_far = 1'h1;
		#40;
	end
	// Released line shows the inverse so stale data never passes
	dat = ~dat;
	busy = 1'h0;
end

////////////////////////////////////////////////////////////////////////////
// Wire levels: the block wins while it drives; otherwise the far clock on the clock pins, and SDA high unless sda_pull
assign sda = pin_out.sda_oe ? pin_out.sda_o : !sda_pull;
assign scl = pin_out.scl_oe ? pin_out.scl_o : clk_far;
assign ch0_three_line_clock_pin = pin_out.sck_oe ? pin_out.sck_o : clk_far;
assign si0 = dat;
endmodule : serial0_far_end

//--- serial0_mode_pin_control_test.sv
// Self-checking bench for the channel zero mode and pin control.
`timescale 1ns/1ps
module serial0_mode_pin_control_test;
localparam int HD = 2; // Short half period keeps the run brief
logic MCLK = 0, RESET = 1, WATCHDOG_STACK_RESET = 0, CE_RESET = 0;
logic CLOCK_STOP = 0, READ = 0, WRITE = 0, SHIFT_OUT = 1;
logic [7:0] ADDRESS = 8'h00;
logic [31:0] WRITEDATA = 32'h0;
logic [3:0] BYTEENABLE = 4'hF;
logic [31:0] READDATA, rd;
logic WAITREQUEST, SHIFT_IN, SHIFT_SAMPLE, SHIFT_ADVANCE, IRQ;
logic SDA_IN, SCL_IN, CH0_THREE_LINE_CLOCK_PIN_IN, SI0_IN, far_go = 0, far_pull = 0, far_busy;
logic [4:0] PIN_SERIAL;
serial0_pkg::pin_out_s PIN_OUT;
logic [7:0] rx_byte = 8'h00; // Bits gathered at each sample pulse
logic [3:0] mv; // Mode value under test
int n_fail = 0, cmp_count = 0, n_samp = 0, n_adv = 0;

always #5 MCLK = ~MCLK;

serial0_mode_pin_control #(.HALF_DIV(HD)) dut_u (.MCLK(MCLK),
	.RESET(RESET), .WATCHDOG_STACK_RESET(WATCHDOG_STACK_RESET),
	.CE_RESET(CE_RESET), .CLOCK_STOP(CLOCK_STOP), .ADDRESS(ADDRESS),
	.READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
	.BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
	.WAITREQUEST(WAITREQUEST), .SDA_IN(SDA_IN), .SCL_IN(SCL_IN),
	.CH0_THREE_LINE_CLOCK_PIN_IN(CH0_THREE_LINE_CLOCK_PIN_IN), .SI0_IN(SI0_IN), .PIN_OUT(PIN_OUT),
	.PIN_SERIAL(PIN_SERIAL), .SHIFT_OUT(SHIFT_OUT), .SHIFT_IN(SHIFT_IN),
	.SHIFT_SAMPLE(SHIFT_SAMPLE), .SHIFT_ADVANCE(SHIFT_ADVANCE), .IRQ(IRQ));

serial0_far_end far_u (.pin_out(PIN_OUT), .go(far_go),
	.sda_pull(far_pull), .tx_byte(8'hA5), .busy(far_busy), .sda(SDA_IN),
	.scl(SCL_IN), .ch0_three_line_clock_pin(CH0_THREE_LINE_CLOCK_PIN_IN), .si0(SI0_IN));

////////////////////////////////////////////////////////////////////////////
// Gather sampled bits mid-cycle, clear of the edge updates
always @(negedge MCLK) begin
	if (SHIFT_SAMPLE === 1'h1) begin
		n_samp++;
		rx_byte = {rx_byte[6:0], SHIFT_IN};
	end
	// Falling shift clock pulses, one per bit
	if (SHIFT_ADVANCE === 1'h1) begin
		n_adv++;
	end
end

task automatic check_reg(input string nm, input logic [31:0] e,
	input logic [31:0] g);
	cmp_count++;
	if (g !== e) begin
		n_fail++;
		$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
	end
endtask : check_reg

task automatic check_pin(input string nm, input logic [7:0] e,
	input logic [7:0] g);
	cmp_count++;
	if (g !== e) begin
		n_fail++;
		$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
	end
endtask : check_pin

// Bus cycle held until waitrequest is seen low at a rising edge
task automatic bus_write(input logic [5:0] idx, input logic [3:0] v,
	input logic [3:0] be);
	@(posedge MCLK);
	ADDRESS <= {idx, 2'h0};
	WRITEDATA <= {28'h0, v};
	BYTEENABLE <= be;
	WRITE <= 1'h1;
	// Waitrequest is judged at the rising edge; the write lands there
	do @(posedge MCLK); while (WAITREQUEST !== 1'h0);
	WRITE <= 1'h0;
endtask : bus_write

task automatic bus_read(input logic [5:0] idx);
	@(posedge MCLK);
	ADDRESS <= {idx, 2'h0};
	READ <= 1'h1;
	// Read data is taken at the same edge that sees waitrequest low
	do @(posedge MCLK); while (WAITREQUEST !== 1'h0);
	rd = READDATA;
	READ <= 1'h0;
endtask : bus_read

task automatic rd_chk(input string nm, input logic [5:0] idx,
	input logic [31:0] e);
	bus_read(idx);
	check_reg(nm, e, rd);
endtask : rd_chk

// Pulse one of the three soft resets for a single cycle
task automatic soft_pulse(input int k);
	@(posedge MCLK);
	{CLOCK_STOP, CE_RESET, WATCHDOG_STACK_RESET} <= 3'h1 << k;
	@(posedge MCLK);
	{CLOCK_STOP, CE_RESET, WATCHDOG_STACK_RESET} <= 3'h0;
endtask : soft_pulse

// Expected enables {sda, scl, sck, so}; bus mode is data dependent
function automatic logic [3:0] exp_oe(input logic [3:0] m);
	case (m[3:2])
		2'h2: return {m[0], m[1], 2'h0};
		2'h3: return {2'h0, m[1], m[0]};
		default: return 4'h0;
	endcase
endfunction : exp_oe

// Expected ownership {si0, so0, ch0_three_line_clock_pin, scl, sda}
function automatic logic [4:0] exp_own(input logic [3:0] m);
	case (m[3:2])
		2'h0: return 5'h00;
		2'h3: return {1'h1, m[0], 1'h1, 2'h0};
		default: return 5'h03;
	endcase
endfunction : exp_own

task automatic results;
	$display("Counts: %0d compared, %0d failed", cmp_count, n_fail);
	if (n_fail == 0 && cmp_count > 0)
		$display("Run complete: PASS");
	else
		$display("Run complete: FAIL");
	$finish;
endtask : results

////////////////////////////////////////////////////////////////////////////
// Watchdog: the whole sequence needs a few hundred cycles
initial begin
	repeat (20000) @(posedge MCLK);
	n_fail++;
	results();
end

initial begin
	repeat (5) @(posedge MCLK);
	RESET <= 1'h0;
	rd_chk("mode", serial0_pkg::IDX_MODE, 32'h0);
	check_pin("own", 8'h00, {3'h0, PIN_SERIAL});
	bus_write(6'h3F, 4'hF, 4'hF);
	rd_chk("unmapped", 6'h3F, 32'h0);
	bus_write(serial0_pkg::IDX_MODE, 4'hF, 4'hE);
	rd_chk("be0", serial0_pkg::IDX_MODE, 32'h0);
	$display("Test reset and refusals done");
	// Every mode value: readback and ownership; drive enables outside bus mode
	for (int m = 0; m < 16; m++) begin
		mv = 4'(m);
		bus_write(serial0_pkg::IDX_MODE, mv, 4'h1);
		rd_chk("mode rw", serial0_pkg::IDX_MODE, {28'h0, mv});
		repeat (3) @(posedge MCLK);
		check_pin("own", {3'h0, exp_own(mv)}, {3'h0, PIN_SERIAL});
		if (mv[3:2] != 2'h1)
			check_pin("oe", {4'h0, exp_oe(mv)}, {4'h0, PIN_OUT.sda_oe,
				PIN_OUT.scl_oe, PIN_OUT.sck_oe, PIN_OUT.so_oe});
	end
	bus_write(serial0_pkg::IDX_CLK_SEL, 4'h3, 4'h1);
	rd_chk("clk_sel", serial0_pkg::IDX_CLK_SEL, 32'h3);
	bus_write(serial0_pkg::IDX_CLK_SEL, 4'h0, 4'h1);
	bus_write(serial0_pkg::IDX_WAIT_CTRL, 4'h3, 4'h1);
	bus_read(serial0_pkg::IDX_WAIT_CTRL);
	check_reg("wait_cond", 32'h3, rd & 32'h3);
	rd_chk("irq_clear", serial0_pkg::IDX_IRQ_CLEAR, 32'h0);
	$display("Test modes and registers done");
	// Master three-line transmit pauses at count eight
	bus_write(serial0_pkg::IDX_MODE, 4'hF, 4'h1);
	bus_write(serial0_pkg::IDX_IRQ_ENABLE, 4'h1, 4'h1);
	bus_write(serial0_pkg::IDX_WAIT_CTRL, 4'h1, 4'h1);
	SHIFT_OUT <= 1'h0;
	n_samp = 0;
	n_adv = 0;
	bus_write(serial0_pkg::IDX_WAIT_CTRL, 4'h5, 4'h1);
	rd = 32'h0;
	repeat (60) if (rd[0] !== 1'h1) bus_read(serial0_pkg::IDX_WAIT_STAT);
	check_reg("waiting", 32'h1, rd);
	check_pin("samples", 8'h8, 8'(n_samp));
	check_pin("advances", 8'h8, 8'(n_adv));
	check_pin("so_o", 8'h0, {7'h0, PIN_OUT.so_o});
	rd_chk("status", serial0_pkg::IDX_STATUS, 32'h8);
	rd_chk("irq_stat", serial0_pkg::IDX_IRQ_STATUS, 32'h3);
	check_pin("irq on", 8'h1, {7'h0, IRQ});
	bus_write(serial0_pkg::IDX_IRQ_ENABLE, 4'h0, 4'h1);
	repeat (2) @(posedge MCLK);
	check_pin("irq mask", 8'h0, {7'h0, IRQ});
	bus_write(serial0_pkg::IDX_IRQ_CLEAR, 4'h7, 4'h1);
	bus_write(serial0_pkg::IDX_IRQ_ENABLE, 4'h1, 4'h1);
	repeat (2) @(posedge MCLK);
	check_pin("irq clr", 8'h0, {7'h0, IRQ});
	bus_write(serial0_pkg::IDX_WAIT_CTRL, 4'h4, 4'h1);
	rd_chk("released", serial0_pkg::IDX_WAIT_STAT, 32'h0);
	$display("Test master transfer done");
	// Each soft reset clears the mode register
	for (int k = 0; k < 3; k++) begin
		bus_write(serial0_pkg::IDX_MODE, 4'hF, 4'h1);
		soft_pulse(k);
		rd_chk("soft", serial0_pkg::IDX_MODE, 32'h0);
	end
	// Slave three-line receive on the far clock
	bus_write(serial0_pkg::IDX_MODE, 4'hC, 4'h1);
	bus_write(serial0_pkg::IDX_WAIT_CTRL, 4'h5, 4'h1);
	n_samp = 0;
	far_go <= 1'h1;
	repeat (3) @(posedge MCLK);
	while (far_busy) @(posedge MCLK);
	far_go <= 1'h0;
	repeat (6) @(posedge MCLK);
	check_pin("rx_byte", 8'hA5, rx_byte);
	check_pin("samples", 8'h8, 8'(n_samp));
	rd_chk("waiting", serial0_pkg::IDX_WAIT_STAT, 32'h1);
	soft_pulse(1);
	$display("Test slave receive done");
	// Bus mode start and stop seen on the wires
	bus_write(serial0_pkg::IDX_MODE, 4'h4, 4'h1);
	bus_write(serial0_pkg::IDX_IRQ_CLEAR, 4'h7, 4'h1);
	far_pull <= 1'h1;
	repeat (6) @(posedge MCLK);
	rd_chk("start", serial0_pkg::IDX_STATUS, 32'h3);
	bus_write(serial0_pkg::IDX_IRQ_MODE, 4'h3, 4'h1);
	far_pull <= 1'h0;
	repeat (6) @(posedge MCLK);
	rd_chk("stop", serial0_pkg::IDX_STATUS, 32'h0);
	rd_chk("stop irq", serial0_pkg::IDX_IRQ_STATUS, 32'h5);
	$display("Test start and stop done");
	results();
end
endmodule : serial0_mode_pin_control_test
